// >>> hw/pmm_pkg.sv
// Purpose: Constants and types for the port pin mode mux
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Byte addresses below are the bus addresses
`default_nettype none
package pmm_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_PULLUP = 8'h08;
	localparam logic [7:0] ADDR_ANALOG = 8'h0c;
	localparam logic [7:0] ADDR_IRQSEL = 8'h10;
	localparam logic [7:0] ADDR_PORT_BASE = 8'h20;
	localparam logic [7:0] ADDR_PORT_STRIDE = 8'h10;
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_DIR = 4'h4;
	localparam logic [3:0] OFS_PIN = 4'h8;
	localparam int NUM_PORTS = 3;
	localparam int PORT_W = 8;
	localparam int IRQ_LSB = 5;
	localparam int IRQ_W = 3;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_PULLUP = 6'h00;
	localparam logic [2:0] RST_IRQSEL = 3'h0;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_EXPAND,
		MODE_MPU
	} pmm_mode_e;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} pmm_pin_drive_s;

	typedef struct packed {
		logic proc_strap;
		logic byte_strap;
		logic valid;
	} pmm_strap_s;
endpackage
`default_nettype wire

// >>> hw/pmm_sync2.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs asynchronous to core_clk
// Notes: First stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module pmm_sync2 #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> hw/pmm_top.sv
// Purpose: Pin function selection for ports 0 to 2 and strap handling
// Assumes: Straps and pins asynchronous; ext data bus signals on core_clk
// Notes: APB with one wait state on every access
`timescale 1ns/100ps
`default_nettype none
module pmm_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic processor_mode_strap,
	input wire logic bus_width_strap,
	input wire logic [7:0] port_zero_pins_in,
	output logic [7:0] port_zero_pins_out,
	output logic [7:0] port_zero_pins_oe,
	output logic [7:0] port_zero_pins_pu,
	input wire logic [7:0] port_one_pins_in,
	output logic [7:0] port_one_pins_out,
	output logic [7:0] port_one_pins_oe,
	output logic [7:0] port_one_pins_pu,
	input wire logic [7:0] port_two_pins_in,
	output logic [7:0] port_two_pins_out,
	output logic [7:0] port_two_pins_oe,
	output logic [7:0] port_two_pins_pu,
	input wire logic [15:0] ext_data_wr,
	input wire logic ext_data_drive,
	output logic [15:0] ext_data_rd,
	output logic ext_bus_on,
	output logic ext_bus_16bit,
	output logic straps_valid,
	output logic [7:0] adc_ext_ch_en,
	output logic [2:0] ext_irq_capable_pins_lvl
);
	localparam int ALL_W = pmm_pkg::NUM_PORTS * pmm_pkg::PORT_W;

	logic [ALL_W-1:0] pins_raw;
	logic [ALL_W-1:0] pins_sync;
	logic [1:0] strap_sync;
	logic [1:0] settle_r;
	pmm_pkg::pmm_strap_s strap_r;
	pmm_pkg::pmm_mode_e mode;
	logic expand_req_r;
	logic [5:0] pullup_r;
	logic [7:0] analog_r;
	logic [2:0] irqsel_r;
	logic [7:0] dout_r [pmm_pkg::NUM_PORTS];
	logic [7:0] dir_r [pmm_pkg::NUM_PORTS];
	pmm_pkg::pmm_pin_drive_s drv_nxt [pmm_pkg::NUM_PORTS];
	logic bus_p0;
	logic bus_p1;
	logic single;
	logic acc;
	logic wr_en;
	logic hit;
	logic [31:0] rd_nxt;

	// Port index of an address, or NUM_PORTS when none
	function automatic logic [1:0] port_of(input logic [7:0] a);
		logic [1:0] idx;
		idx = 2'(pmm_pkg::NUM_PORTS);
		for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
			if (a[7:4] == 4'((pmm_pkg::ADDR_PORT_BASE + 8'(i) * pmm_pkg::ADDR_PORT_STRIDE) >> 4)) begin
				idx = 2'(i);
			end
		end
		return idx;
	endfunction

	// Offset within a port block
	function automatic logic [3:0] port_ofs(input logic [7:0] a);
		return a[3:0];
	endfunction

	assign pins_raw = {port_two_pins_in, port_one_pins_in, port_zero_pins_in};

	pmm_sync2 #(
		.WIDTH(ALL_W)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(pins_raw),
		.q(pins_sync)
	);

	pmm_sync2 #(
		.WIDTH(2)
	) u_strap_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d({processor_mode_strap, bus_width_strap}),
		.q(strap_sync)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_r <= '0;
			strap_r <= '0;
		end else if (!strap_r.valid) begin
			if (settle_r == pmm_pkg::STRAP_SETTLE) begin
				strap_r.proc_strap <= strap_sync[1];
				strap_r.byte_strap <= strap_sync[0];
				strap_r.valid <= 1'b1;
			end else begin
				settle_r <= settle_r + 2'h1;
			end
		end
	end

	// Mode from strap and expansion request
	always_comb begin
		if (strap_r.proc_strap) begin
			mode = pmm_pkg::MODE_MPU;
		end else if (expand_req_r) begin
			mode = pmm_pkg::MODE_EXPAND;
		end else begin
			mode = pmm_pkg::MODE_SINGLE;
		end
	end

	assign single = (mode == pmm_pkg::MODE_SINGLE);
	// Bus ownership of ports 0 and 1
	assign bus_p0 = strap_r.valid && !single;
	// Upper byte only on a 16-bit bus
	assign bus_p1 = bus_p0 && !strap_r.byte_strap;

	assign acc = psel && penable && !pready;
	assign wr_en = psel && penable && pready && pwrite;

	always_comb begin
		hit = 1'b1;
		rd_nxt = '0;
		case (paddr)
			pmm_pkg::ADDR_STATUS: begin
				rd_nxt[0] = strap_r.proc_strap;
				rd_nxt[1] = strap_r.byte_strap;
				rd_nxt[2] = strap_r.valid;
				rd_nxt[3] = bus_p0;
				rd_nxt[5:4] = mode;
			end
			pmm_pkg::ADDR_MODE: rd_nxt[0] = expand_req_r;
			pmm_pkg::ADDR_PULLUP: rd_nxt[5:0] = pullup_r;
			pmm_pkg::ADDR_ANALOG: rd_nxt[7:0] = analog_r;
			pmm_pkg::ADDR_IRQSEL: rd_nxt[2:0] = irqsel_r;
			default: begin
				if (port_of(paddr) == 2'(pmm_pkg::NUM_PORTS)) begin
					hit = 1'b0;
				end else begin
					case (port_ofs(paddr))
						pmm_pkg::OFS_DATA: rd_nxt[7:0] = dout_r[port_of(paddr)];
						pmm_pkg::OFS_DIR: rd_nxt[7:0] = dir_r[port_of(paddr)];
						pmm_pkg::OFS_PIN: rd_nxt[7:0] = pins_sync[port_of(paddr)*8 +: 8];
						default: hit = 1'b0;
					endcase
				end
			end
		endcase
	end

	// Bus answer one cycle into access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= acc;
			pslverr <= acc && !hit;
			prdata <= (acc && !pwrite) ? rd_nxt : 32'h0000_0000;
		end
	end

	// Control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			expand_req_r <= 1'b0;
			pullup_r <= pmm_pkg::RST_PULLUP;
			analog_r <= pmm_pkg::RST_BYTE;
			irqsel_r <= pmm_pkg::RST_IRQSEL;
		end else if (wr_en) begin
			case (paddr)
				pmm_pkg::ADDR_MODE: expand_req_r <= pwdata[0] && !strap_r.proc_strap;
				pmm_pkg::ADDR_PULLUP: pullup_r <= pwdata[5:0];
				pmm_pkg::ADDR_ANALOG: analog_r <= pwdata[7:0];
				pmm_pkg::ADDR_IRQSEL: irqsel_r <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
				dout_r[i] <= pmm_pkg::RST_BYTE;
				dir_r[i] <= pmm_pkg::RST_BYTE;
			end
		end else if (wr_en && port_of(paddr) != 2'(pmm_pkg::NUM_PORTS)) begin
			if (port_ofs(paddr) == pmm_pkg::OFS_DATA) begin
				dout_r[port_of(paddr)] <= pwdata[7:0];
			end
			if (port_ofs(paddr) == pmm_pkg::OFS_DIR) begin
				dir_r[port_of(paddr)] <= pwdata[7:0];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
			drv_nxt[i].out = dout_r[i];
			drv_nxt[i].oe = strap_r.valid ? dir_r[i] : 8'h00;
			// Nibble pull-ups, single-chip only, input pins
			drv_nxt[i].pu = (single && strap_r.valid) ?
				({{4{pullup_r[2*i+1]}}, {4{pullup_r[2*i]}}} & ~dir_r[i]) : 8'h00;
		end
		if (single) begin
			drv_nxt[0].oe = drv_nxt[0].oe & ~analog_r;
		end
		// External data bus on port 0, upper byte on port 1 for a 16-bit bus
		if (bus_p0) begin
			drv_nxt[0].out = ext_data_wr[7:0];
			drv_nxt[0].oe = {8{ext_data_drive}};
		end
		if (bus_p1) begin
			drv_nxt[1].out = ext_data_wr[15:8];
			drv_nxt[1].oe = {8{ext_data_drive}};
		end
	end

	// Registered pin drive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{port_zero_pins_out, port_zero_pins_oe, port_zero_pins_pu} <= '0;
			{port_one_pins_out, port_one_pins_oe, port_one_pins_pu} <= '0;
			{port_two_pins_out, port_two_pins_oe, port_two_pins_pu} <= '0;
		end else begin
			{port_zero_pins_out, port_zero_pins_oe, port_zero_pins_pu} <= drv_nxt[0];
			{port_one_pins_out, port_one_pins_oe, port_one_pins_pu} <= drv_nxt[1];
			{port_two_pins_out, port_two_pins_oe, port_two_pins_pu} <= drv_nxt[2];
		end
	end

	// Status and side-function outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_data_rd <= '0;
			ext_bus_on <= 1'b0;
			ext_bus_16bit <= 1'b0;
			straps_valid <= 1'b0;
			adc_ext_ch_en <= '0;
			ext_irq_capable_pins_lvl <= '0;
		end else begin
			// Data read back from bus pins
			ext_data_rd <= {bus_p1 ? pins_sync[15:8] : 8'h00, bus_p0 ? pins_sync[7:0] : 8'h00};
			ext_bus_on <= bus_p0;
			ext_bus_16bit <= bus_p1;
			straps_valid <= strap_r.valid;
			adc_ext_ch_en <= (single && strap_r.valid) ? analog_r : 8'h00;
			// Interrupt pins on port 1 upper bits
			ext_irq_capable_pins_lvl <= bus_p1 ? 3'h0 :
				irqsel_r & pins_sync[pmm_pkg::PORT_W + pmm_pkg::IRQ_LSB +: pmm_pkg::IRQ_W];
		end
	end
endmodule
`default_nettype wire

// >>> tb/pmm_chk.sv
// Purpose: Port checks on the pin mode mux
// Assumes: One clock, async active-low reset
// Notes: Bound to pmm_top
`timescale 1ns/100ps
`default_nettype none
module pmm_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] port_zero_pins_out,
	input wire logic [7:0] port_zero_pins_oe,
	input wire logic [7:0] port_zero_pins_pu,
	input wire logic [15:0] ext_data_wr,
	input wire logic ext_data_drive,
	input wire logic ext_bus_on,
	input wire logic ext_bus_16bit,
	input wire logic straps_valid,
	input wire logic [2:0] ext_irq_capable_pins_lvl
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("No ready after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("Ready too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("Error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("Read data outside answer");
	a_pu_off_bus: assert property (ext_bus_on && $past(ext_bus_on) |-> port_zero_pins_pu == 8'h00)
		else $error("Pull-up in bus mode");
	a_pu_not_out: assert property ((port_zero_pins_pu & port_zero_pins_oe) == 8'h00)
		else $error("Pull-up on output");
	a_wide_needs_bus: assert property (ext_bus_16bit |-> ext_bus_on)
		else $error("Wide bus without bus");
	a_irq_off_wide: assert property (ext_bus_16bit && $past(ext_bus_16bit) |-> ext_irq_capable_pins_lvl == 3'h0)
		else $error("Irq level while bus");
	a_straps_hold: assert property (straps_valid |=> straps_valid)
		else $error("Strap latch lost");
	a_quiet_unlatched: assert property (!straps_valid |-> port_zero_pins_oe == 8'h00)
		else $error("Drive before latch");
	a_bus_drive: assert property (ext_bus_on && $past(ext_bus_on) && $past(ext_data_drive) |-> {8'h00, port_zero_pins_out} == ($past(ext_data_wr) & 16'h00ff))
		else $error("Bus low byte wrong");
	c_err: cover property (pready && pslverr);
	c_wide: cover property (ext_bus_16bit && ext_data_drive);
	c_irq: cover property (ext_irq_capable_pins_lvl != 3'h0);
endmodule
bind pmm_top pmm_chk u_chk (.*);
`default_nettype wire

// >>> tb/pmm_pin_far.sv
// Purpose: Board side of one eight-pin port
// Assumes: Far side drives when enabled
// Notes: Released pins show inverse of last drive unless pulled up
`timescale 1ns/100ps
`default_nettype none
module pmm_pin_far (
	input wire logic core_clk,
	input wire logic [7:0] oe,
	input wire logic [7:0] out,
	input wire logic [7:0] pu,
	input wire logic far_en,
	input wire logic [7:0] far_val,
	output logic [7:0] pin
);
	assign pin = (oe & out) | (~oe & (far_en ? far_val : (pu | ~out)));
endmodule
`default_nettype wire

// >>> tb/pmm_tb_top.sv
// Purpose: Self-checking bench for pmm_top
// Assumes: APB master and board model
// Notes: Single, expansion and mpu modes
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error at %0t got %h exp %h", $time, a, b); end end
module pmm_tb_top;
	localparam logic [7:0] DIR0 = 8'h24;
	localparam logic [7:0] PIN0 = 8'h28;
	logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, processor_mode_strap = 1'h0, bus_width_strap = 1'h0;
	logic [7:0] port_zero_pins_in, port_zero_pins_out, port_zero_pins_oe, port_zero_pins_pu;
	logic [7:0] port_one_pins_in, port_one_pins_out, port_one_pins_oe, port_one_pins_pu;
	logic [7:0] port_two_pins_in, port_two_pins_out, port_two_pins_oe, port_two_pins_pu;
	logic [15:0] ext_data_wr = 16'h0, ext_data_rd, w;
	logic ext_data_drive = 1'h0, ext_bus_on, ext_bus_16bit, straps_valid, far_en = 1'h1;
	logic [7:0] adc_ext_ch_en, fv0 = 8'h00, fv1 = 8'h00, lf = 8'h5c, d;
	logic [2:0] ext_irq_capable_pins_lvl;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int n_mismatch = 0, num_checks = 0;
	pmm_top dut (.*);
	pmm_pin_far u_f0 (.core_clk(core_clk), .oe(port_zero_pins_oe), .out(port_zero_pins_out),
		.pu(port_zero_pins_pu), .far_en(far_en), .far_val(fv0), .pin(port_zero_pins_in));
	pmm_pin_far u_f1 (.core_clk(core_clk), .oe(port_one_pins_oe), .out(port_one_pins_out),
		.pu(port_one_pins_pu), .far_en(far_en), .far_val(fv1), .pin(port_one_pins_in));
	pmm_pin_far u_f2 (.core_clk(core_clk), .oe(port_two_pins_oe), .out(port_two_pins_out),
		.pu(port_two_pins_pu), .far_en(far_en), .far_val(8'h3c), .pin(port_two_pins_in));
	initial forever #25 core_clk = ~core_clk;
	function automatic logic [7:0] rnd();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] ex);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'h1;
		if (!wr) exp_q.push_back(ex);
		do @(posedge core_clk); while (!pready);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_valid();
		repeat (20) if (!straps_valid) @(posedge core_clk);
	endtask
	task automatic close_out();
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (pready && !pwrite) begin
			e = exp_q.pop_front();
			`CHK({pslverr, prdata}, e)
		end
	end
	initial begin
		#100us;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		wait_valid();
		apb(1'h0, pmm_pkg::ADDR_STATUS, 32'h0, 33'h4);
		d = rnd();
		apb(1'h1, DIR0, {24'h0, d}, 33'h0);
		apb(1'h0, DIR0, 32'h0, {25'h0, d});
		apb(1'h1, pmm_pkg::ADDR_PORT_BASE, 32'h5a, 33'h0);
		apb(1'h1, pmm_pkg::ADDR_PULLUP, 32'h9, 33'h0);
		apb(1'h1, pmm_pkg::ADDR_IRQSEL, 32'h7, 33'h0);
		fv0 <= rnd();
		fv1 <= 8'ha0;
		w[7:0] = rnd();
		apb(1'h1, pmm_pkg::ADDR_ANALOG, {24'h0, w[7:0]}, 33'h0);
		repeat (6) @(posedge core_clk);
		`CHK(port_zero_pins_oe, d & ~w[7:0])
		`CHK(port_zero_pins_out, 8'h5a)
		`CHK({port_one_pins_pu, port_zero_pins_pu}, {8'hf0, 8'h0f & ~d})
		`CHK(ext_irq_capable_pins_lvl, 3'h5)
		`CHK(adc_ext_ch_en, w[7:0])
		`CHK(port_zero_pins_oe & adc_ext_ch_en, 8'h00)
		apb(1'h0, PIN0, 32'h0, {25'h0, (d & ~w[7:0] & 8'h5a) | (~(d & ~w[7:0]) & fv0)});
		// Board released, pull-ups or inverse of pin out decide
		far_en <= 1'h0;
		repeat (4) @(posedge core_clk);
		apb(1'h0, PIN0, 32'h0, {25'h0, (d & ~w[7:0] & 8'h5a) | (~(d & ~w[7:0]) & ((8'h0f & ~d) | 8'ha5))});
		far_en <= 1'h1;
		apb(1'h0, 8'h1c, 32'h0, {1'h1, 32'h0});
		apb(1'h1, pmm_pkg::ADDR_MODE, 32'h1, 33'h0);
		apb(1'h0, pmm_pkg::ADDR_STATUS, 32'h0, 33'h1c);
		w = {rnd(), rnd()};
		ext_data_wr <= w;
		ext_data_drive <= 1'h1;
		repeat (2) @(posedge core_clk);
		`CHK({port_one_pins_out, port_zero_pins_out}, w)
		`CHK({ext_bus_16bit, port_zero_pins_pu}, 9'h100)
		ext_data_drive <= 1'h0;
		fv0 <= w[15:8];
		fv1 <= w[7:0];
		repeat (6) @(posedge core_clk);
		`CHK(ext_data_rd, {w[7:0], w[15:8]})
		rst_n <= 1'h0;
		processor_mode_strap <= 1'h1;
		bus_width_strap <= 1'h1;
		@(posedge core_clk);
		`CHK(port_one_pins_out, 8'h00)
		@(posedge core_clk);
		rst_n <= 1'h1;
		wait_valid();
		apb(1'h0, pmm_pkg::ADDR_STATUS, 32'h0, 33'h2f);
		apb(1'h1, pmm_pkg::ADDR_MODE, 32'h1, 33'h0);
		apb(1'h0, pmm_pkg::ADDR_MODE, 32'h0, 33'h0);
		`CHK(ext_bus_16bit, 1'h0)
		// Let the last read answer be compared
		@(posedge core_clk);
		close_out();
	end
endmodule
`default_nettype wire
